/* File: common/lsbt_pkg.sv */
package lsbt_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] SINK_ENABLE_CONTROL_OFS   = 8'h10;
  localparam logic [7:0] SINK_BLINK_TIME_UPPER_OFS = 8'h11;
  localparam logic [7:0] SINK_ENABLE_CONTROL_RST   = 8'h00;
  localparam logic [7:0] SINK_BLINK_TIME_UPPER_RST = 8'h00;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int NUM_SINKS         = 7;
  localparam int ENABLE_LSB        = 0;
  localparam int ENABLE_MSB        = 6;
  localparam int SHARED_ON_LSB     = 6;
  localparam int SINK_7_OFF_LSB    = 4;
  localparam int SINK_6_OFF_LSB    = 2;
  localparam int SINK_5_OFF_LSB    = 0;
  localparam logic [1:0] OFF_DISABLED = 2'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ      = 25_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int TICK_CYC    = CLK_HZ / MS_PER_S;
  localparam int CYC_W       = 15;
  localparam int MS_W        = 11;
  localparam int ON_MS_0     = 200;
  localparam int ON_MS_1     = 600;
  localparam int ON_MS_2     = 800;
  localparam int ON_MS_3     = 1200;
  localparam int OFF_MS_1    = 600;
  localparam int OFF_MS_2    = 1200;
  localparam int OFF_MS_3    = 1800;

  typedef enum logic [1:0] {
    LSBT_IDLE = 2'h0,
    LSBT_ON   = 2'h1,
    LSBT_OFF  = 2'h3
  } lsbt_phase_e;

  function automatic logic [MS_W-1:0] lsbt_on_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    lsbt_on_ms = MS_W'(ON_MS_0);
      2'h1:    lsbt_on_ms = MS_W'(ON_MS_1);
      2'h2:    lsbt_on_ms = MS_W'(ON_MS_2);
      default: lsbt_on_ms = MS_W'(ON_MS_3);
    endcase
  endfunction

  // A disabled off time returns zero; callers never count against it.
  function automatic logic [MS_W-1:0] lsbt_off_ms(input logic [1:0] sel);
    case (sel)
      2'h1:    lsbt_off_ms = MS_W'(OFF_MS_1);
      2'h2:    lsbt_off_ms = MS_W'(OFF_MS_2);
      2'h3:    lsbt_off_ms = MS_W'(OFF_MS_3);
      default: lsbt_off_ms = '0;
    endcase
  endfunction

endpackage

/* File: core/lsbt_led_sink_blink_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module lsbt_led_sink_blink_timer #(
  parameter int TICK_CYC_P = lsbt_pkg::TICK_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [7:0]                 sink_lo_off_time,
  output logic [7:0]                      reg_rdata_q,
  output logic [lsbt_pkg::NUM_SINKS-1:0]  sink_on_q
);
  import lsbt_pkg::*;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]           ctl_q, ctl_d;
  logic [7:0]           time_q, time_d;
  logic [7:0]           reg_rdata_d;
  logic [2*NUM_SINKS-1:0] off_all;
  logic [NUM_SINKS-1:0] sink_on;

  always_comb begin
    ctl_d       = ctl_q;
    time_d      = time_q;
    reg_rdata_d = reg_rdata_q;
    if (reg_wr && reg_addr == SINK_ENABLE_CONTROL_OFS) begin
      // One write moves every enable in the same cycle.
      ctl_d = {1'b0, reg_wdata[ENABLE_MSB:ENABLE_LSB]};
    end
    if (reg_wr && reg_addr == SINK_BLINK_TIME_UPPER_OFS) begin
      time_d = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        SINK_ENABLE_CONTROL_OFS:   reg_rdata_d = ctl_q;
        SINK_BLINK_TIME_UPPER_OFS: reg_rdata_d = time_q;
        default:                   reg_rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_q       <= SINK_ENABLE_CONTROL_RST;
      time_q      <= SINK_BLINK_TIME_UPPER_RST;
      reg_rdata_q <= 8'h00;
    end else begin
      ctl_q       <= ctl_d;
      time_q      <= time_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // ****************************************************************
  // Per-sink timers
  // ****************************************************************
  // Sinks one to four take their off times from the neighbouring register.
  assign off_all = {time_q[SINK_7_OFF_LSB+:2], time_q[SINK_6_OFF_LSB+:2],
                    time_q[SINK_5_OFF_LSB+:2], sink_lo_off_time};

  for (genvar i = 0; i < NUM_SINKS; i++) begin : g_sink
    lsbt_sink_timer #(
      .TICK_CYC_P (TICK_CYC_P)
    ) u_timer (
      .clk             (clk),
      .rst_n           (rst_n),
      .sink_n_enable   (ctl_q[i]),
      .shared_on_time  (time_q[SHARED_ON_LSB+:2]),
      .sink_n_off_time (off_all[2*i+:2]),
      .sink_on_q       (sink_on[i])
    );
  end

  assign sink_on_q = sink_on;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_lo_off;
    @(posedge clk) disable iff (!rst_n)
      (ctl_q[3:0] == 4'h0) |=> sink_on_q[3:0] == 4'h0;
  endproperty
  a_lo_off: assert property (p_lo_off) else $error("low sinks not off");

  property p_hi_en;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == SINK_ENABLE_CONTROL_OFS)
      |=> ctl_q == {1'b0, $past(reg_wdata[6:0])} ##1
          (sink_on_q[6:4] & ~ctl_q[6:4]) == 3'h0;
  endproperty
  a_hi_en: assert property (p_hi_en) else $error("high enables wrong");

  property p_time_map;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == SINK_BLINK_TIME_UPPER_OFS)
      |=> off_all[13:8] == $past(reg_wdata[5:0])
          && time_q[7:6] == $past(reg_wdata[7:6]);
  endproperty
  a_time_map: assert property (p_time_map) else $error("timing map wrong");

  property p_group;
    @(posedge clk) disable iff (!rst_n)
      (ctl_q == 8'h00 && reg_wr && reg_addr == SINK_ENABLE_CONTROL_OFS)
      |-> ##2 sink_on_q == $past(reg_wdata[6:0], 2);
  endproperty
  a_group: assert property (p_group) else $error("group start skewed");

  property p_on_then_off;
    @(posedge clk) disable iff (!rst_n)
      ($fell(sink_on_q[0]) && ctl_q[0]) |-> off_all[1:0] != OFF_DISABLED;
  endproperty
  a_on_then_off: assert property (p_on_then_off) else $error("bad turn off");

  property p_rd_ctl;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == SINK_ENABLE_CONTROL_OFS)
      |=> reg_rdata_q == $past(ctl_q);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("enable readback wrong");

  property p_rd_time;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == SINK_BLINK_TIME_UPPER_OFS)
      |=> reg_rdata_q == $past(time_q);
  endproperty
  a_rd_time: assert property (p_rd_time) else $error("timing readback wrong");

  property p_rsvd;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == SINK_ENABLE_CONTROL_OFS) |=> !reg_rdata_q[7];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  property p_rd_unmapped;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr != SINK_ENABLE_CONTROL_OFS
       && reg_addr != SINK_BLINK_TIME_UPPER_OFS) |=> reg_rdata_q == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");

  property p_rd_hold;
    @(posedge clk) disable iff (!rst_n)
      !reg_rd |=> $stable(reg_rdata_q);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

  property p_wr_hold;
    @(posedge clk) disable iff (!rst_n)
      !reg_wr |=> $stable(ctl_q) && $stable(time_q);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("register moved");

  property p_hi_off;
    @(posedge clk) disable iff (!rst_n)
      (ctl_q[6:4] == 3'h0) |=> sink_on_q[6:4] == 3'h0;
  endproperty
  a_hi_off: assert property (p_hi_off) else $error("high sinks not off");

  property p_steady_six;
    @(posedge clk) disable iff (!rst_n)
      (ctl_q[5] && $past(ctl_q[5]) && time_q[SINK_6_OFF_LSB+:2] == OFF_DISABLED)
      |=> sink_on_q[5];
  endproperty
  a_steady_six: assert property (p_steady_six) else $error("sink 6 not on");

endmodule
`default_nettype wire

/* File: core/lsbt_sink_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module lsbt_sink_timer #(
  parameter int TICK_CYC_P = 25000
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sink_n_enable,
  input  wire logic [1:0] shared_on_time,
  input  wire logic [1:0] sink_n_off_time,
  output logic            sink_on_q
);
  import lsbt_pkg::*;

  lsbt_phase_e           phase_q, phase_d;
  logic [CYC_W-1:0]      cyc_q, cyc_d;
  logic [MS_W-1:0]       ms_q, ms_d;
  logic                  sink_on_d;
  logic                  tick;
  logic                  blinking;

  assign tick     = (cyc_q == CYC_W'(TICK_CYC_P - 1));
  assign blinking = (sink_n_off_time != OFF_DISABLED);

  always_comb begin
    phase_d   = phase_q;
    cyc_d     = tick ? '0 : cyc_q + CYC_W'(1);
    ms_d      = tick ? ms_q + MS_W'(1) : ms_q;
    case (phase_q)
      LSBT_IDLE: begin
        cyc_d = '0;
        ms_d  = '0;
        if (sink_n_enable) begin
          phase_d = LSBT_ON;
        end
      end
      LSBT_ON: begin
        if (!blinking) begin
          // Held on; timers parked so a later off time gets a full on phase.
          cyc_d = '0;
          ms_d  = '0;
        end else if (tick && ms_q == lsbt_on_ms(shared_on_time) - 1) begin
          phase_d = LSBT_OFF;
          ms_d    = '0;
        end
      end
      LSBT_OFF: begin
        if (!blinking) begin
          phase_d = LSBT_ON;
          cyc_d   = '0;
          ms_d    = '0;
        end else if (tick && ms_q == lsbt_off_ms(sink_n_off_time) - 1) begin
          phase_d = LSBT_ON;
          ms_d    = '0;
        end
      end
      default: begin
        phase_d = LSBT_IDLE;
        cyc_d   = '0;
        ms_d    = '0;
      end
    endcase
    if (!sink_n_enable) begin
      phase_d = LSBT_IDLE;
      cyc_d   = '0;
      ms_d    = '0;
    end
    sink_on_d = (phase_d == LSBT_ON);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q   <= LSBT_IDLE;
      cyc_q     <= '0;
      ms_q      <= '0;
      sink_on_q <= 1'b0;
    end else begin
      phase_q   <= phase_d;
      cyc_q     <= cyc_d;
      ms_q      <= ms_d;
      sink_on_q <= sink_on_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_on_len;
    @(posedge clk) disable iff (!rst_n)
      (phase_q == LSBT_ON ##1 phase_q == LSBT_OFF)
      |-> ($past(ms_q) == lsbt_on_ms($past(shared_on_time)) - 1) && !sink_on_q;
  endproperty
  a_on_len: assert property (p_on_len) else $error("on phase length wrong");

  property p_off_len;
    @(posedge clk) disable iff (!rst_n)
      (phase_q == LSBT_OFF && blinking ##1 phase_q == LSBT_ON)
      |-> $past(ms_q) == lsbt_off_ms($past(sink_n_off_time)) - 1;
  endproperty
  a_off_len: assert property (p_off_len) else $error("off phase length wrong");

  property p_off_ends;
    @(posedge clk) disable iff (!rst_n)
      (phase_q == LSBT_OFF && sink_n_enable && blinking && tick
       && ms_q == lsbt_off_ms(sink_n_off_time) - 1) |=> sink_on_q;
  endproperty
  a_off_ends: assert property (p_off_ends) else $error("sink not back on");

  property p_steady;
    @(posedge clk) disable iff (!rst_n)
      (sink_n_enable && !blinking && phase_q != LSBT_IDLE) |=> sink_on_q;
  endproperty
  a_steady: assert property (p_steady) else $error("steady sink not on");

  property p_start;
    @(posedge clk) disable iff (!rst_n)
      $rose(sink_n_enable) |=> sink_on_q && ms_q == '0 && cyc_q == '0;
  endproperty
  a_start: assert property (p_start) else $error("enable did not start");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
      !sink_n_enable |=> phase_q == LSBT_IDLE && ms_q == '0 && !sink_on_q;
  endproperty
  a_clear: assert property (p_clear) else $error("disable did not reset");

endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import lsbt_pkg::*;

  // ****************************************************************
  // Bench setup
  // ****************************************************************
  // A short millisecond keeps the slowest on and off phases affordable.
  localparam int TK = 2;
  logic                 clk;
  logic                 rst_n;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [7:0]           reg_addr;
  logic [7:0]           reg_wdata;
  logic [7:0]           sink_lo_off_time;
  logic [7:0]           reg_rdata_q;
  logic [NUM_SINKS-1:0] sink_on_q;
  int                   fails;
  int                   cmp_count;

  lsbt_led_sink_blink_timer #(.TICK_CYC_P(TK)) u_dut (
    .clk              (clk),
    .rst_n            (rst_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .sink_lo_off_time (sink_lo_off_time),
    .reg_rdata_q      (reg_rdata_q),
    .sink_on_q        (sink_on_q)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic int on_cyc(input logic [1:0] c);
    case (c)
      2'h0:    return 200 * TK;
      2'h1:    return 600 * TK;
      2'h2:    return 800 * TK;
      default: return 1200 * TK;
    endcase
  endfunction

  function automatic int off_cyc(input logic [1:0] c);
    return 600 * TK * int'(c);
  endfunction

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkc(input string nm, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      fails++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    step();
    reg_wr    = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd   = 1'b1;
    step();
    reg_rd   = 1'b0;
    chk8("read data", e, reg_rdata_q);
  endtask

  // Counts cycles while one sink keeps the given level, with a bound.
  task automatic run_len(input int s, input logic lvl, output int n);
    n = 0;
    while (sink_on_q[s] === lvl && n < 10000) begin
      n++;
      step();
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    int n;
    int s;
    logic [1:0] onc;
    logic [1:0] offc;
    logic [7:0] t;
    logic [7:0] lo;
    fails = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sink_lo_off_time = 8'h00;
    void'($urandom(32'he4c4));
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd_chk(SINK_ENABLE_CONTROL_OFS, 8'h00);
    step();
    rd_chk(SINK_BLINK_TIME_UPPER_OFS, 8'h00);
    wr(8'h12, 8'hff);
    rd_chk(8'h12, 8'h00);
    wr(SINK_ENABLE_CONTROL_OFS, 8'hff);
    rd_chk(SINK_ENABLE_CONTROL_OFS, 8'h7f);
    n = 0;
    repeat (3000) begin
      if (sink_on_q === 7'h7f) n++;
      step();
    end
    chkc("steady on cycles", 3000, n);
    wr(SINK_ENABLE_CONTROL_OFS, 8'h00);
    step();
    chk8("sinks cleared", 8'h00, 8'(sink_on_q));
    // All sinks enabled in one write must blink in lock step.
    sink_lo_off_time = 8'h55;
    wr(SINK_BLINK_TIME_UPPER_OFS, 8'h55);
    step();
    wr(SINK_ENABLE_CONTROL_OFS, 8'h7f);
    step();
    chk8("group start", 8'h7f, 8'(sink_on_q));
    repeat (on_cyc(2'h1) - 1) step();
    chk8("group last on", 8'h7f, 8'(sink_on_q));
    step();
    chk8("group off", 8'h00, 8'(sink_on_q));
    wr(SINK_ENABLE_CONTROL_OFS, 8'h00);
    step();
    for (int k = 0; k < 12; k++) begin
      onc  = 2'(k % 4);
      offc = 2'(k % 3 + 1);
      s    = int'($urandom_range(6, 0));
      t    = {onc, 6'($urandom())};
      lo   = 8'($urandom());
      if (s < 4) lo[2*s +: 2] = offc;
      else t[2*(s-4) +: 2] = offc;
      sink_lo_off_time = lo;
      wr(SINK_BLINK_TIME_UPPER_OFS, t);
      rd_chk(SINK_BLINK_TIME_UPPER_OFS, t);
      wr(SINK_ENABLE_CONTROL_OFS, 8'(1) << s);
      chk8("before start", 8'h00, 8'(sink_on_q));
      step();
      chk8("one sink on", 8'(1) << s, 8'(sink_on_q));
      run_len(s, 1'b1, n);
      chkc("on phase", on_cyc(onc), n);
      run_len(s, 1'b0, n);
      chkc("off phase", off_cyc(offc), n);
      run_len(s, 1'b1, n);
      chkc("second on phase", on_cyc(onc), n);
      repeat (5) step();
      wr(SINK_ENABLE_CONTROL_OFS, 8'h00);
      step();
      chk8("sink disabled", 8'h00, 8'(sink_on_q));
    end
    give_verdict();
  end

  initial begin
    #(40 * 100000);
    fails++;
    give_verdict();
  end

endmodule
`default_nettype wire
